// ==== hw/cam_switch_pkg.sv ====
// Shared constants and types for the calendar cam switch
`default_nettype none
package cam_switch_pkg;
	// ==========================================
	// Cam count and widths of calendar fields
	localparam int NUM_CAMS  = 3;
	localparam int DAYS_W    = 7;
	localparam int WDAY_W    = 3;
	localparam int HOUR_W    = 5;
	localparam int MIN_W     = 6;
	localparam int YEAR_W    = 7;
	localparam int MONTH_W   = 4;
	localparam int DAY_W     = 5;
	// ==========================================
	// Legal ranges and reset values
	localparam logic [HOUR_W-1:0]  HOUR_MAX     = 5'h17;
	localparam logic [MIN_W-1:0]   MIN_MAX      = 6'h3B;
	localparam logic [WDAY_W-1:0]  WDAY_NONE    = 3'h7;
	localparam logic [HOUR_W-1:0]  HOUR_RST     = 5'h00;
	localparam logic [MIN_W-1:0]   MIN_RST      = 6'h00;
	localparam logic [YEAR_W-1:0]  YEAR_RST     = 7'h00;
	localparam logic [MONTH_W-1:0] MONTH_NONE   = 4'h0;
	localparam logic [DAY_W-1:0]   DAY_NONE     = 5'h00;
	// ==========================================
	// Date switch repeat modes
	typedef enum logic [1:0] {
		MODE_ONCE    = 2'b00,
		MODE_YEARLY  = 2'b01,
		MODE_MONTHLY = 2'b10
	} date_mode_t;
endpackage
`default_nettype wire

// ==== hw/cam_if.sv ====
// Bundle between the weekday switch core and one cam matcher
`default_nettype none
interface cam_if;
	logic [cam_switch_pkg::DAYS_W-1:0] day_mask;
	logic [cam_switch_pkg::HOUR_W-1:0] on_hour;
	logic [cam_switch_pkg::MIN_W-1:0]  on_minute;
	logic                              on_set;
	logic [cam_switch_pkg::HOUR_W-1:0] off_hour;
	logic [cam_switch_pkg::MIN_W-1:0]  off_minute;
	logic                              off_set;
	logic [cam_switch_pkg::WDAY_W-1:0] weekday;
	logic [cam_switch_pkg::HOUR_W-1:0] hour;
	logic [cam_switch_pkg::MIN_W-1:0]  minute;
	logic                              minute_new;
	logic                              on_hit;
	logic                              off_hit;
	modport core (
		output day_mask, on_hour, on_minute, on_set, off_hour, off_minute, off_set,
		output weekday, hour, minute, minute_new,
		input  on_hit, off_hit
	);
	modport cam (
		input  day_mask, on_hour, on_minute, on_set, off_hour, off_minute, off_set,
		input  weekday, hour, minute, minute_new,
		output on_hit, off_hit
	);
endinterface
`default_nettype wire

// ==== hw/cam_match.sv ====
// One weekday cam: decides whether its on or off moment is reached
`default_nettype none
module cam_match (
	cam_if.cam c
);
	// ==========================================
	// Day selection and moment checks
	logic day_hit;
	logic on_legal;
	logic off_legal;

	// Any mix of weekdays, one bit each
	assign day_hit = (c.weekday != cam_switch_pkg::WDAY_NONE)
		&& c.day_mask[c.weekday]; // [R2]

	// Moments limited to 00:00 .. 23:59
	assign on_legal  = (c.on_hour <= cam_switch_pkg::HOUR_MAX)
		&& (c.on_minute <= cam_switch_pkg::MIN_MAX); // [R6]
	assign off_legal = (c.off_hour <= cam_switch_pkg::HOUR_MAX)
		&& (c.off_minute <= cam_switch_pkg::MIN_MAX); // [R6]

	// Hits fire only in the first evaluation of a minute
	assign c.on_hit = c.minute_new && day_hit && c.on_set && on_legal // [R8] [R9]
		&& (c.hour == c.on_hour) && (c.minute == c.on_minute); // [R3] [R18]
	assign c.off_hit = c.minute_new && day_hit && c.off_set && off_legal // [R8] [R9]
		&& (c.hour == c.off_hour) && (c.minute == c.off_minute); // [R4] [R18]
endmodule
`default_nettype wire

// ==== hw/calendar_cam_switch.sv ====
// Calendar cam switch: three-cam weekday switch and one-cam date switch
// What this block does
// [R1] Weekday switch has three independent cams
// [R2] Any weekday combination selectable per cam
// [R3] On moment drives output high
// [R4] Off moment drives output low
// [R5] Higher-numbered cam wins on conflicts
// [R6] Moments are hours and minutes, 00:00-23:59
// [R7] Pulse cam asserts output one processing cycle
// [R8] Unset moment never switches
// [R9] On and off moments disable independently
// [R10] Weekday output comes only from cams
// [R11] Date switch output high while cam on
// [R12] Yearly: high from on date to off date
// [R13] Yearly pulse: one cycle, off date ignored
// [R14] Yearly switching only within year range
// [R15] Neither yearly nor monthly: acts once, never repeats
// [R16] Monthly: on day high, off day low
// [R17] Off date is month then day
// [R18] Evaluate per cycle, fire on first match
`default_nettype none
module calendar_cam_switch (
	input  wire logic                                 core_clk,
	input  wire logic                                 rst,
	input  wire logic                                 cycle_tick,
	input  wire logic [cam_switch_pkg::WDAY_W-1:0]    now_weekday,
	input  wire logic [cam_switch_pkg::HOUR_W-1:0]    now_hour,
	input  wire logic [cam_switch_pkg::MIN_W-1:0]     now_minute,
	input  wire logic [cam_switch_pkg::YEAR_W-1:0]    now_year,
	input  wire logic [cam_switch_pkg::MONTH_W-1:0]   now_month,
	input  wire logic [cam_switch_pkg::DAY_W-1:0]     now_day,
	input  wire logic [2:0][cam_switch_pkg::DAYS_W-1:0] cam_day_mask,
	input  wire logic [2:0][cam_switch_pkg::HOUR_W-1:0] cam_on_hour,
	input  wire logic [2:0][cam_switch_pkg::MIN_W-1:0]  cam_on_minute,
	input  wire logic [2:0]                           cam_on_set,
	input  wire logic [2:0][cam_switch_pkg::HOUR_W-1:0] cam_off_hour,
	input  wire logic [2:0][cam_switch_pkg::MIN_W-1:0]  cam_off_minute,
	input  wire logic [2:0]                           cam_off_set,
	input  wire logic [2:0]                           cam_pulse,
	input  wire logic [cam_switch_pkg::YEAR_W-1:0]    date_on_year,
	input  wire logic [cam_switch_pkg::MONTH_W-1:0]   date_on_month,
	input  wire logic [cam_switch_pkg::DAY_W-1:0]     date_on_day,
	input  wire logic [cam_switch_pkg::YEAR_W-1:0]    date_off_year,
	input  wire logic [cam_switch_pkg::MONTH_W-1:0]   date_off_month,
	input  wire logic [cam_switch_pkg::DAY_W-1:0]     date_off_day,
	input  wire logic                                 date_yearly,
	input  wire logic                                 date_monthly,
	input  wire logic                                 date_pulse,
	output logic                                      week_out,
	output logic                                      date_out
);
	// ==========================================
	// Declarations
	logic [cam_switch_pkg::WDAY_W-1:0]  last_wday_r;
	logic [cam_switch_pkg::HOUR_W-1:0]  last_hour_r;
	logic [cam_switch_pkg::MIN_W-1:0]   last_min_r;
	logic [cam_switch_pkg::YEAR_W-1:0]  last_year_r;
	logic [cam_switch_pkg::MONTH_W-1:0] last_month_r;
	logic [cam_switch_pkg::DAY_W-1:0]   last_day_r;
	logic                               minute_new;
	logic                               day_new;
	logic [2:0]                         on_hit;
	logic [2:0]                         off_hit;
	logic                               week_level_r;
	logic                               week_level_nxt;
	logic                               week_pulse_nxt;
	logic                               week_out_r;
	logic                               date_level_r;
	logic                               date_level_nxt;
	logic                               date_pulse_nxt;
	logic                               date_out_r;
	logic                               once_done_r;
	logic                               once_done_nxt;
	logic                               in_range;
	logic                               on_match;
	logic                               off_match;
	cam_switch_pkg::date_mode_t         mode;

	// ==========================================
	// Processing cycle edge detection
	// New minute: first tick whose stamp differs
	assign minute_new = cycle_tick && ((now_weekday != last_wday_r)
		|| (now_hour != last_hour_r) || (now_minute != last_min_r)); // [R18]

	// New date: first tick whose date differs
	assign day_new = cycle_tick && ((now_year != last_year_r)
		|| (now_month != last_month_r) || (now_day != last_day_r)); // [R18]

	// Remember the last evaluated minute
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			last_wday_r <= cam_switch_pkg::WDAY_NONE;
			last_hour_r <= cam_switch_pkg::HOUR_RST;
			last_min_r  <= cam_switch_pkg::MIN_RST;
		end else if (cycle_tick) begin
			last_wday_r <= now_weekday; // [R18]
			last_hour_r <= now_hour;
			last_min_r  <= now_minute;
		end
	end

	// Remember the last evaluated date
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			last_year_r  <= cam_switch_pkg::YEAR_RST;
			last_month_r <= cam_switch_pkg::MONTH_NONE;
			last_day_r   <= cam_switch_pkg::DAY_NONE;
		end else if (cycle_tick) begin
			last_year_r  <= now_year; // [R18]
			last_month_r <= now_month;
			last_day_r   <= now_day;
		end
	end

	// ==========================================
	// Weekday switch cams
	// One matcher per cam
	for (genvar i = 0; i < cam_switch_pkg::NUM_CAMS; i++) begin : g_cam
		cam_if c_if ();

		assign c_if.day_mask   = cam_day_mask[i]; // [R1]
		assign c_if.on_hour    = cam_on_hour[i];
		assign c_if.on_minute  = cam_on_minute[i];
		assign c_if.on_set     = cam_on_set[i]; // [R9]
		assign c_if.off_hour   = cam_off_hour[i];
		assign c_if.off_minute = cam_off_minute[i];
		assign c_if.off_set    = cam_off_set[i]; // [R9]
		assign c_if.weekday    = now_weekday;
		assign c_if.hour       = now_hour;
		assign c_if.minute     = now_minute;
		assign c_if.minute_new = minute_new;
		assign on_hit[i]       = c_if.on_hit;
		assign off_hit[i]      = c_if.off_hit;

		cam_match u_cam (
			.c (c_if.cam)
		);
	end

	// ==========================================
	// Weekday switch state
	// Apply cams in order so later cams override
	always_comb begin
		week_level_nxt = week_level_r;
		week_pulse_nxt = 1'b0;
		for (int i = 0; i < cam_switch_pkg::NUM_CAMS; i++) begin
			if (on_hit[i]) begin
				if (cam_pulse[i]) begin
					week_level_nxt = 1'b0; // [R7]
					week_pulse_nxt = 1'b1; // [R7]
				end else begin
					week_level_nxt = 1'b1; // [R3]
					week_pulse_nxt = 1'b0; // [R5]
				end
			end
			if (off_hit[i]) begin
				week_level_nxt = 1'b0; // [R4]
				week_pulse_nxt = 1'b0; // [R5]
			end
		end
	end

	// Level held between processing cycles
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			week_level_r <= 1'b0;
		end else if (cycle_tick) begin
			week_level_r <= week_level_nxt; // [R10]
		end
	end

	// Output updated once per processing cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			week_out_r <= 1'b0;
		end else if (cycle_tick) begin
			week_out_r <= week_level_nxt | week_pulse_nxt; // [R7] [R10]
		end
	end

	assign week_out = week_out_r;

	// ==========================================
	// Date switch decode
	// Monthly overrides yearly, else once
	always_comb begin
		if (date_monthly) begin
			mode = cam_switch_pkg::MODE_MONTHLY;
		end else if (date_yearly) begin
			mode = cam_switch_pkg::MODE_YEARLY;
		end else begin
			mode = cam_switch_pkg::MODE_ONCE;
		end
	end

	// Year window, inclusive at both ends
	assign in_range = (now_year >= date_on_year) && (now_year <= date_off_year); // [R14]

	// Matches for the chosen mode
	always_comb begin
		unique case (mode)
			cam_switch_pkg::MODE_MONTHLY: begin
				on_match  = in_range && (now_day == date_on_day); // [R16]
				off_match = in_range && (now_day == date_off_day); // [R16]
			end
			cam_switch_pkg::MODE_YEARLY: begin
				on_match  = in_range && (now_month == date_on_month)
					&& (now_day == date_on_day); // [R12] [R14]
				off_match = in_range && (now_month == date_off_month)
					&& (now_day == date_off_day); // [R12] [R17]
			end
			cam_switch_pkg::MODE_ONCE: begin
				on_match  = !once_done_r && (now_year == date_on_year)
					&& (now_month == date_on_month)
					&& (now_day == date_on_day); // [R15]
				off_match = (now_year == date_off_year)
					&& (now_month == date_off_month)
					&& (now_day == date_off_day); // [R15] [R17]
			end
			default: begin
				on_match  = 1'b0;
				off_match = 1'b0;
			end
		endcase
	end

	// ==========================================
	// Date switch state
	// Next level, pulse and one-shot flag
	always_comb begin
		date_level_nxt = date_level_r;
		date_pulse_nxt = 1'b0;
		once_done_nxt  = once_done_r;
		if (day_new) begin
			if (date_pulse) begin
				date_level_nxt = 1'b0; // [R13]
				date_pulse_nxt = on_match; // [R13]
			end else if (on_match) begin
				date_level_nxt = 1'b1; // [R11] [R12]
			end else if (off_match) begin
				date_level_nxt = 1'b0; // [R12] [R16] [R17]
			end
			if (on_match && (mode == cam_switch_pkg::MODE_ONCE)) begin
				once_done_nxt = 1'b1; // [R15]
			end
		end
	end

	// Level held between processing cycles
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			date_level_r <= 1'b0;
		end else if (cycle_tick) begin
			date_level_r <= date_level_nxt; // [R11]
		end
	end

	// Single-shot memory for non-repeating mode
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			once_done_r <= 1'b0;
		end else if (cycle_tick) begin
			once_done_r <= once_done_nxt; // [R15]
		end
	end

	// Output updated once per processing cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			date_out_r <= 1'b0;
		end else if (cycle_tick) begin
			date_out_r <= date_level_nxt | date_pulse_nxt; // [R11] [R13]
		end
	end

	assign date_out = date_out_r;
endmodule
`default_nettype wire

// ==== testbench/cam_switch_properties.sv ====
// Concurrent checks on the calendar cam switch ports
`default_nettype none
module cam_switch_properties (
	input wire logic                                core_clk,
	input wire logic                                rst,
	input wire logic                                cycle_tick,
	input wire logic [cam_switch_pkg::YEAR_W-1:0]   now_year,
	input wire logic [2:0]                          cam_on_set,
	input wire logic [2:0]                          cam_off_set,
	input wire logic [2:0]                          cam_pulse,
	input wire logic [cam_switch_pkg::YEAR_W-1:0]   date_on_year,
	input wire logic [cam_switch_pkg::YEAR_W-1:0]   date_off_year,
	input wire logic                                date_yearly,
	input wire logic                                date_monthly,
	input wire logic                                date_pulse,
	input wire logic                                week_out,
	input wire logic                                date_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ==========================================
	// Weekday switch, plus idle and reset checks on both outputs
	hold_idle_a: assert property (!cycle_tick |=> $stable(week_out) && $stable(date_out))
		else $error("output moved without a tick");
	rst_clear_a: assert property ($past(rst) |-> !week_out && !date_out)
		else $error("output high after reset");
	week_rise_a: assert property ($rose(week_out) |-> $past(cycle_tick) && $past(cam_on_set) != 3'h0)
		else $error("week output rose without an on moment");
	no_on_rise_a: assert property (cycle_tick && cam_on_set == 3'h0 && !week_out |=> !week_out)
		else $error("unset on moment switched");
	no_off_fall_a: assert property (cycle_tick && cam_off_set == 3'h0 && cam_pulse == 3'h0
		&& week_out |=> week_out)
		else $error("unset off moment switched");
	pulse_end_a: assert property (cycle_tick && week_out && cam_pulse == 3'h7
		&& cam_on_set == 3'h0 |=> !week_out)
		else $error("week pulse too long");
	// ==========================================
	// Date switch
	date_pulse_a: assert property (cycle_tick && date_out && date_pulse |=> !date_out)
		else $error("date pulse too long");
	date_range_a: assert property (cycle_tick && (date_yearly || date_monthly)
		&& (now_year < date_on_year || now_year > date_off_year) |=> $stable(date_out))
		else $error("date switched outside year range");
endmodule
`default_nettype wire

// ==== testbench/calendar_cam_switch_tb_top.sv ====
// Self-checking bench for the calendar cam switch
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %b want %b", $time, a, e); end end
module calendar_cam_switch_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic            core_clk = 1'b0;
	logic            rst = 1'b1;
	logic            cycle_tick = 1'b0;
	logic [2:0]      now_weekday = 3'h0;
	logic [4:0]      now_hour = 5'h00;
	logic [5:0]      now_minute = 6'h00;
	logic [6:0]      now_year = 7'h00;
	logic [3:0]      now_month = 4'h1;
	logic [4:0]      now_day = 5'h01;
	logic [2:0][6:0] cam_day_mask = '0;
	logic [2:0][4:0] cam_on_hour = '0;
	logic [2:0][5:0] cam_on_minute = '0;
	logic [2:0][4:0] cam_off_hour = '0;
	logic [2:0][5:0] cam_off_minute = '0;
	logic [2:0]      cam_on_set = 3'h0;
	logic [2:0]      cam_off_set = 3'h0;
	logic [2:0]      cam_pulse = 3'h0;
	logic [6:0]      date_on_year = 7'h00;
	logic [3:0]      date_on_month = 4'h0;
	logic [4:0]      date_on_day = 5'h00;
	logic [6:0]      date_off_year = 7'h00;
	logic [3:0]      date_off_month = 4'h0;
	logic [4:0]      date_off_day = 5'h00;
	logic            date_yearly = 1'b0;
	logic            date_monthly = 1'b0;
	logic            date_pulse = 1'b0;
	logic            week_out;
	logic            date_out;
	int              n_errors = 0;
	int              n_tests = 0;
	// ==========================================
	// Clock and device
	always #20 core_clk = ~core_clk;
	calendar_cam_switch dut (.core_clk, .rst, .cycle_tick, .now_weekday, .now_hour,
		.now_minute, .now_year, .now_month, .now_day, .cam_day_mask, .cam_on_hour,
		.cam_on_minute, .cam_on_set, .cam_off_hour, .cam_off_minute, .cam_off_set,
		.cam_pulse, .date_on_year, .date_on_month, .date_on_day, .date_off_year,
		.date_off_month, .date_off_day, .date_yearly, .date_monthly, .date_pulse,
		.week_out, .date_out);
	// ==========================================
	// Tasks
	// One processing cycle strobe
	task go;
		@(posedge core_clk);
		#1;
		cycle_tick = 1'b1;
		@(posedge core_clk);
		#1;
		cycle_tick = 1'b0;
	endtask
	// Weekday tick and check
	task wt(input logic [2:0] wd, input logic [4:0] h, input logic [5:0] mi, input logic e);
		{now_weekday, now_hour, now_minute} = {wd, h, mi};
		go();
		`CHK(week_out, e)
	endtask
	// Date tick and check
	task dt(input logic [6:0] y, input logic [3:0] mo, input logic [4:0] d, input logic e);
		{now_year, now_month, now_day} = {y, mo, d};
		go();
		`CHK(date_out, e)
	endtask
	// Cam days and moments
	task cfg(input int i, input logic [6:0] m, input logic [4:0] a, input logic [5:0] b,
		input logic [4:0] c, input logic [5:0] d);
		{cam_day_mask[i], cam_on_hour[i], cam_on_minute[i], cam_off_hour[i],
			cam_off_minute[i]} = {m, a, b, c, d};
	endtask
	task wrap_up;
		if (n_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (20) @(posedge core_clk);
		#1;
		rst = 1'b0;
		// Daily cam 06:30 to 08:00
		cfg(0, 7'h7F, 5'h06, 6'h1E, 5'h08, 6'h00);
		cam_on_set = 3'h1;
		cam_off_set = 3'h1;
		wt(3'h0, 5'h06, 6'h1D, 1'b0);
		wt(3'h0, 5'h06, 6'h1E, 1'b1);
		wt(3'h0, 5'h06, 6'h1E, 1'b1);
		wt(3'h3, 5'h08, 6'h00, 1'b0);
		// Monday on, Wednesday off from another cam
		cfg(0, 7'h01, 5'h07, 6'h00, 5'h00, 6'h00);
		cfg(1, 7'h04, 5'h07, 6'h00, 5'h0D, 6'h07);
		cam_off_set = 3'h0;
		wt(3'h2, 5'h07, 6'h00, 1'b0);
		wt(3'h0, 5'h07, 6'h00, 1'b1);
		wt(3'h1, 5'h0D, 6'h07, 1'b1);
		cam_off_set = 3'h2;
		wt(3'h2, 5'h0D, 6'h07, 1'b0);
		// Sunday only at the last minute
		cfg(2, 7'h40, 5'h17, 6'h3B, 5'h00, 6'h00);
		cam_on_set = 3'h4;
		cam_off_set = 3'h0;
		wt(3'h5, 5'h17, 6'h3B, 1'b0);
		wt(3'h6, 5'h17, 6'h3B, 1'b1);
		// Conflicting moments between cams
		cfg(0, 7'h7F, 5'h0A, 6'h00, 5'h0C, 6'h00);
		cfg(1, 7'h7F, 5'h0B, 6'h00, 5'h0A, 6'h00);
		cfg(2, 7'h7F, 5'h0C, 6'h00, 5'h0B, 6'h00);
		cam_on_set = 3'h7;
		cam_off_set = 3'h7;
		wt(3'h0, 5'h0A, 6'h00, 1'b0);
		wt(3'h0, 5'h0B, 6'h00, 1'b0);
		wt(3'h0, 5'h0C, 6'h00, 1'b1);
		// Pulse cam
		cfg(0, 7'h7F, 5'h05, 6'h00, 5'h00, 6'h00);
		cam_pulse = 3'h7;
		cam_on_set = 3'h1;
		cam_off_set = 3'h0;
		wt(3'h0, 5'h05, 6'h00, 1'b1);
		cam_on_set = 3'h0;
		wt(3'h0, 5'h05, 6'h01, 1'b0);
		cam_pulse = 3'h0;
		// Yearly June 1 to August 31, years 8 to 10
		{date_on_year, date_on_month, date_on_day} = {7'h08, 4'h6, 5'h01};
		{date_off_year, date_off_month, date_off_day} = {7'h0A, 4'h8, 5'h1F};
		date_yearly = 1'b1;
		dt(7'h09, 4'h5, 5'h1F, 1'b0);
		dt(7'h09, 4'h6, 5'h01, 1'b1);
		dt(7'h09, 4'h7, 5'h01, 1'b1);
		dt(7'h09, 4'h8, 5'h1F, 1'b0);
		dt(7'h0B, 4'h6, 5'h01, 1'b0);
		dt(7'h07, 4'h6, 5'h01, 1'b0);
		dt(7'h0A, 4'h6, 5'h01, 1'b1);
		dt(7'h0A, 4'h8, 5'h1F, 1'b0);
		// Yearly pulse on March 15
		{date_on_month, date_on_day, date_pulse} = {4'h3, 5'h0F, 1'b1};
		dt(7'h09, 4'h3, 5'h0F, 1'b1);
		dt(7'h09, 4'h3, 5'h10, 1'b0);
		date_pulse = 1'b0;
		// Monthly, day 1 to day 5
		{date_on_day, date_off_day, date_monthly} = {5'h01, 5'h05, 1'b1};
		dt(7'h09, 4'h2, 5'h01, 1'b1);
		dt(7'h09, 4'h2, 5'h05, 1'b0);
		dt(7'h09, 4'h3, 5'h01, 1'b1);
		dt(7'h0B, 4'h3, 5'h05, 1'b1);
		dt(7'h0A, 4'h3, 5'h05, 1'b0);
		// Single shot on exact dates
		{date_yearly, date_monthly} = 2'h0;
		{date_on_year, date_on_month, date_on_day} = {7'h08, 4'h6, 5'h01};
		{date_off_year, date_off_month, date_off_day} = {7'h08, 4'h8, 5'h1F};
		dt(7'h08, 4'h6, 5'h01, 1'b1);
		dt(7'h08, 4'h8, 5'h1F, 1'b0);
		dt(7'h09, 4'h6, 5'h01, 1'b0);
		// Same exact on date again must not fire a second time
		dt(7'h08, 4'h6, 5'h01, 1'b0);
		wrap_up();
	end
	// Watchdog
	initial begin
		repeat (4000) @(posedge core_clk);
		n_errors++;
		wrap_up();
	end
endmodule
bind calendar_cam_switch cam_switch_properties props (.core_clk, .rst, .cycle_tick,
	.now_year, .cam_on_set, .cam_off_set, .cam_pulse, .date_on_year, .date_off_year,
	.date_yearly, .date_monthly, .date_pulse, .week_out, .date_out);
`default_nettype wire
